// file: bench/apb_host_model.sv
module apb_host_model (
    // clock
    input wire pclk,
    // request lines
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    // answer and hang flag
    input wire pready,
    output logic timed_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {psel, penable, pwrite, paddr, pwdata, timed_out} = '0;
    end
    // request held until pready is seen; bounded so a dead slave cannot hang us
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        // pready is sampled at the rising edge; the request is released at the edge it is seen, or after 20 edges without it
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        timed_out <= (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// file: bench/debug_otp_mode_entry_control_assertions.sv
module mode_entry_checker #(
    parameter DBG_CYCLES = 4,
    parameter PRG_CYCLES = 4
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // comparators, state and raw watchdog error
    input wire test_level_above_debug,
    input wire test_level_above_prog,
    input wire fuse_load_state,
    input wire wd_error_in,
    // mode outputs
    input wire debug_active_flag,
    input wire prog_mode,
    input wire transceivers_active,
    input wire wd_infinite,
    input wire init_state,
    input wire [3:0] watchdog_period_field,
    input wire [3:0] watchdog_recovery_field,
    // gated safety outputs
    input wire wd_error,
    input wire reset_timer_expired,
    input wire failsafe_entry,
    input wire safety_fault_output_n
);
    timeunit 1ns;
    timeprecision 1ps;
    int dbg_run;
    int prg_run;
    // unbroken cycles of each level inside fuse-load; any drop restarts it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dbg_run <= 0;
            prg_run <= 0;
        end else begin
            dbg_run <= (fuse_load_state && test_level_above_debug) ? dbg_run + 1 : 0;
            prg_run <= (fuse_load_state && test_level_above_prog) ? prg_run + 1 : 0;
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_dbg_filt;
        $rose(debug_active_flag) |-> dbg_run >= DBG_CYCLES;
    endproperty
    a_dbg_filt: assert property (p_dbg_filt) else $error("debug entry too early");
    property p_prg_filt;
        $rose(prog_mode) |-> prg_run >= PRG_CYCLES;
    endproperty
    a_prg_filt: assert property (p_prg_filt) else $error("prog entry too early");
    property p_prg_wins;
        $rose(debug_active_flag) |-> !prog_mode;
    endproperty
    a_prg_wins: assert property (p_prg_wins) else $error("debug over prog");
    property p_wd_off;
        $past(debug_active_flag) || $past(wd_infinite) |-> !wd_error;
    endproperty
    a_wd_off: assert property (p_wd_off) else $error("watchdog error leaked");
    property p_timer_off;
        $past(debug_active_flag) |-> !reset_timer_expired;
    endproperty
    a_timer_off: assert property (p_timer_off) else $error("reset timer leaked");
    property p_fs_off;
        $past(debug_active_flag) |-> !failsafe_entry;
    endproperty
    a_fs_off: assert property (p_fs_off) else $error("fail-safe leaked");
    property p_fault_low;
        $past(debug_active_flag) |-> !safety_fault_output_n;
    endproperty
    a_fault_low: assert property (p_fault_low) else $error("fault output released");
    property p_trx_on;
        $rose(debug_active_flag) |-> ##[0:1] transceivers_active;
    endproperty
    a_trx_on: assert property (p_trx_on) else $error("transceivers idle");
    property p_restore;
        $past(presetn) && $past(wd_error_in) && !$past(debug_active_flag) && !$past(wd_infinite) |-> wd_error;
    endproperty
    a_restore: assert property (p_restore) else $error("watchdog error lost");
    property p_locked;
        $past(presetn) && !$past(init_state) |-> $stable({watchdog_recovery_field, watchdog_period_field});
    endproperty
    a_locked: assert property (p_locked) else $error("fields changed outside init");
    property p_inf_zero;
        $rose(wd_infinite) && !debug_active_flag |-> {watchdog_recovery_field, watchdog_period_field} == 8'h00;
    endproperty
    a_inf_zero: assert property (p_inf_zero) else $error("infinite without zero fields");
endmodule

bind debug_otp_mode_entry_control mode_entry_checker #(.DBG_CYCLES(DBG_CYCLES), .PRG_CYCLES(PRG_CYCLES)) u_chk (
    .pclk, .presetn, .test_level_above_debug, .test_level_above_prog, .fuse_load_state, .wd_error_in,
    .debug_active_flag, .prog_mode, .transceivers_active, .wd_infinite, .init_state, .watchdog_period_field,
    .watchdog_recovery_field, .wd_error, .reset_timer_expired, .failsafe_entry, .safety_fault_output_n
);

// file: bench/debug_otp_mode_entry_control_tb_top.sv
`include "mode_entry_consts.vh"

module debug_otp_mode_entry_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // short filter keeps the run brief
    localparam FILT = 4;
    logic pclk = 0, presetn = 0, fuse_load_state = 0, normal_state = 1;
    logic test_level_above_debug = 0, test_level_above_prog = 0;
    logic wd_error_in = 0, reset_timer_expired_in = 0, fault_count_max_in = 0, fault_request_in = 0;
    wire psel, penable, pwrite, pready, pslverr, timed_out;
    wire [11:0] paddr;
    wire [31:0] pwdata, prdata;
    wire debug_active_flag, prog_mode, transceivers_active, wd_infinite, init_state;
    wire wd_error, reset_timer_expired, failsafe_entry, safety_fault_output_n;
    wire [3:0] watchdog_period_field, watchdog_recovery_field;
    int err_count = 0, tests_run = 0, seed = 91816, n;
    logic [32:0] exp_q[$];
    logic [31:0] r;

    debug_otp_mode_entry_control #(.DBG_CYCLES(FILT), .PRG_CYCLES(FILT)) u_dut (.*);
    apb_host_model u_host (.*);

    initial forever #10 pclk = ~pclk;

    task chk(input logic [32:0] got, input logic [32:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task rd(input logic [11:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        u_host.xfer(1'b0, a, 32'h0);
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        u_host.xfer(1'b1, a, d);
    endtask
    task do_reset;
        @(posedge pclk) presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    task wait_mode(input logic prog);
        n = 0;
        while ((prog ? prog_mode : debug_active_flag) !== 1'b1) begin
            @(posedge pclk);
            n++;
            if (n > 40) begin
                err_count++;
                final_report;
            end
        end
    endtask
    // read answers checked against the oldest noted expectation
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            chk({pslverr, prdata}, exp_q.pop_front());
        end
    end
    always @(posedge timed_out) begin
        err_count++;
        final_report;
    end
    initial begin
        do_reset;
        rd(`OFS_WDW_CFG, 33'h33);
        rd(`OFS_STATUS, 33'h3);
        rd(12'h010, 33'h100000000);
        $display("test 1 done");
        r = $random(seed) | 32'h1;
        wr(`OFS_WDW_CFG, r);
        rd(`OFS_WDW_CFG, {25'h0, r[7:0]});
        wr(`OFS_WDW_CFG, 32'h0);
        repeat (2) @(posedge pclk);
        chk({wd_infinite, watchdog_recovery_field, watchdog_period_field}, 9'h100);
        wr(`OFS_WDW_CFG, r);
        wr(`OFS_SYS1_CFG, 32'h10);
        wr(`OFS_SYS1_CFG, 32'h20);
        @(posedge pclk);
        chk({init_state, wd_infinite}, 2'b00);
        wr(`OFS_WDW_CFG, 32'h0);
        rd(`OFS_WDW_CFG, {25'h0, r[7:0]});
        $display("test 2 done");
        normal_state <= 1'b0;
        wr(`OFS_SYS_CFG, 32'h1);
        rd(`OFS_STATUS, 33'h0);
        normal_state <= 1'b1;
        rd(`OFS_STATUS, 33'h2);
        wr(`OFS_SYS_CFG, 32'h1);
        rd(`OFS_STATUS, 33'h3);
        wr(`OFS_WDW_CFG, 32'h0);
        wr(`OFS_SYS1_CFG, 32'h10);
        wr(`OFS_SYS1_CFG, 32'h20);
        rd(`OFS_STATUS, 33'h6);
        wd_error_in <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(wd_error, 1'b0);
        wd_error_in <= 1'b0;
        $display("test 3 done");
        // level outside fuse-load, then a short pulse, must not enter
        do_reset;
        test_level_above_debug <= 1'b1;
        repeat (FILT + 4) @(posedge pclk);
        fuse_load_state <= 1'b1;
        repeat (FILT - 1) @(posedge pclk);
        test_level_above_debug <= 1'b0;
        chk(debug_active_flag, 1'b0);
        @(posedge pclk) test_level_above_debug <= 1'b1;
        repeat (FILT) @(posedge pclk);
        chk(debug_active_flag, 1'b0);
        wait_mode(1'b0);
        {fuse_load_state, test_level_above_debug} <= 2'b00;
        {wd_error_in, reset_timer_expired_in, fault_count_max_in, fault_request_in} <= 4'hf;
        repeat (2) @(posedge pclk);
        chk({transceivers_active, wd_error, reset_timer_expired}, 3'h4);
        chk({failsafe_entry, safety_fault_output_n}, 2'h0);
        rd(`OFS_SYS1_CFG, 33'h11);
        wr(`OFS_SYS1_CFG, 32'h2);
        repeat (3) @(posedge pclk);
        chk({debug_active_flag, wd_error, reset_timer_expired}, 3'h3);
        chk({failsafe_entry, safety_fault_output_n}, 2'h2);
        {wd_error_in, reset_timer_expired_in, fault_count_max_in, fault_request_in} <= 4'h0;
        repeat (3) @(posedge pclk);
        chk(safety_fault_output_n, 1'b1);
        rd(`OFS_SYS1_CFG, 33'h10);
        $display("test 4 done");
        {fuse_load_state, test_level_above_debug, test_level_above_prog} <= 3'b111;
        wait_mode(1'b1);
        {fuse_load_state, test_level_above_debug, test_level_above_prog} <= 3'b000;
        rd(`OFS_SYS1_CFG, 33'h14);
        chk(debug_active_flag, 1'b0);
        $display("test 5 done");
        final_report;
    end
endmodule

// file: verilog/debug_otp_mode_entry_control.v
// The implementer's own choices: the address map and the APB slave port.
`include "mode_entry_consts.vh"

// ----------------------------------------
// register map (byte offsets, one aligned 32-bit word each)
// ----------------------------------------
// 0x000 system config:
//   bit 0  enter_init_request, honoured only in normal mode outside init
//   bit 1  transceivers_active, read back as written
// 0x004 secondary system config:
//   bit 0  debug_active_flag, read only
//   bit 1  debug_leave_bit, write one to leave debug mode
//   bit 2  programming mode active, read only
//   bit 4  init lock, write one to clear
//   bit 5  watchdog refresh, write one; leaves init once the lock is clear
// 0x008 safety watchdog config, writable in init only:
//   [3:0] watchdog_period_field, [7:4] watchdog_recovery_field
//   both fields zero select an infinite watchdog period
// 0x00c status, read only:
//   bit 0 init, bit 1 normal, bit 2 infinite watchdog
// unmapped offsets answer with pslverr and read as zero
// byte lanes are not decoded: every write replaces the whole word

module debug_otp_mode_entry_control #(
    parameter DBG_CYCLES = `DBG_FILT_CYCLES,
    parameter PRG_CYCLES = `PRG_FILT_CYCLES
) (
    // apb clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // comparators on the test level pin
    input wire test_level_above_debug,
    input wire test_level_above_prog,
    // main state machine
    input wire fuse_load_state,
    input wire normal_state,
    // raw safety events
    input wire wd_error_in,
    input wire reset_timer_expired_in,
    input wire fault_count_max_in,
    input wire fault_request_in,
    // mode and safety outputs
    output reg debug_active_flag,
    output reg prog_mode,
    output reg transceivers_active,
    output reg wd_infinite,
    output reg init_state,
    output reg [3:0] watchdog_period_field,
    output reg [3:0] watchdog_recovery_field,
    output wire wd_error,
    output wire reset_timer_expired,
    output wire failsafe_entry,
    output wire safety_fault_output_n
);

    // ----------------------------------------
    // mode states (one-hot)
    // ----------------------------------------
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_DEBUG = 3'b010;
    localparam [2:0] ST_PROG = 3'b100;

    reg [2:0] state;
    reg [2:0] next_state;
    reg lock_init;
    wire dbg_pass;
    wire prg_pass;
    wire wr_en;
    wire rd_en;
    wire addr_ok;
    wire wr_sys_cfg;
    wire wr_sys1_cfg;
    wire wr_wdw_cfg;
    reg [31:0] next_rdata;

    // ----------------------------------------
    // entry filters
    // ----------------------------------------
    // both filters run only in the fuse-load state; a wake-up that skips that
    // state therefore never samples the pin and keeps the previous mode
    // the two counts are independent so the priority decision sees both at once
    level_filter #(.CYCLES(DBG_CYCLES), .WIDTH(12)) u_dbg_filter (
        .pclk(pclk),
        .presetn(presetn),
        .enable(fuse_load_state),
        .level(test_level_above_debug),
        .passed(dbg_pass)
    );

    level_filter #(.CYCLES(PRG_CYCLES), .WIDTH(12)) u_prg_filter (
        .pclk(pclk),
        .presetn(presetn),
        .enable(fuse_load_state),
        .level(test_level_above_prog),
        .passed(prg_pass)
    );

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    // zero wait states: every access completes in its first access cycle
    // reads latch their word in the setup cycle; writes land on the access edge
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign addr_ok = (paddr == `OFS_SYS_CFG) || (paddr == `OFS_SYS1_CFG) ||
                     (paddr == `OFS_WDW_CFG) || (paddr == `OFS_STATUS);

    // per-register write strobes, one cycle wide on the access edge
    assign wr_sys_cfg = wr_en && (paddr == `OFS_SYS_CFG);
    assign wr_sys1_cfg = wr_en && (paddr == `OFS_SYS1_CFG);
    assign wr_wdw_cfg = wr_en && (paddr == `OFS_WDW_CFG);

    // ----------------------------------------
    // mode state machine
    // ----------------------------------------
    // one mode at a time; programming mode has no software exit on purpose
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                // a programming level still in its filter holds off debug entry, so a pin that crosses the
                // programming level before the debug filter passes never stops in debug on the way
                if (prg_pass) begin
                    next_state = ST_PROG;
                end else if (dbg_pass && !test_level_above_prog) begin
                    next_state = ST_DEBUG;
                end
            end
            ST_DEBUG: begin
                if (wr_sys1_cfg && pwdata[`BIT_DEBUG_LEAVE]) begin
                    next_state = ST_IDLE;
                end
            end
            ST_PROG: begin
                next_state = ST_PROG;   // left only by power-on reset
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // flags come from next_state so they change on the same edge as the state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            debug_active_flag <= 1'b0;
            prog_mode <= 1'b0;
        end else begin
            state <= next_state;
            debug_active_flag <= (next_state == ST_DEBUG);
            prog_mode <= (next_state == ST_PROG);
        end
    end

    // ----------------------------------------
    // transceiver default on debug entry
    // ----------------------------------------
    // software may still turn them off later through the system config register
    // entry wins over a config write that falls in the same cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            transceivers_active <= 1'b0;
        end else if (state == ST_IDLE && next_state == ST_DEBUG) begin
            transceivers_active <= 1'b1;
        end else if (wr_sys_cfg) begin
            transceivers_active <= pwdata[`BIT_TRX_ACTIVE];
        end
    end

    // ----------------------------------------
    // init state and watchdog configuration
    // ----------------------------------------
    // init is entered at reset; lock clear plus a refresh is the only way out
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_state <= 1'b1;
            lock_init <= 1'b1;
            watchdog_period_field <= `WATCHDOG_PERIOD_FIELD_RST;
            watchdog_recovery_field <= `WATCHDOG_RECOVERY_FIELD_RST;
        end else begin
            // a request outside normal mode is dropped, not held for later
            if (wr_sys_cfg && pwdata[`BIT_ENTER_INIT] && normal_state && !init_state) begin
                init_state <= 1'b1;
                lock_init <= 1'b1;
            end else if (wr_sys1_cfg && init_state) begin
                // the refresh tests the lock as it stood before this write, so lock
                // clear and refresh in one word do not leave init
                if (pwdata[`BIT_LOCK_INIT]) begin
                    lock_init <= 1'b0;
                end
                if (pwdata[`BIT_WD_REFRESH] && !lock_init) begin
                    init_state <= 1'b0;
                end
            end
            // protected fields only writable in init
            // once init is left an all-zero write is ignored too, so no late infinite period
            if (wr_wdw_cfg && init_state) begin
                watchdog_period_field <= pwdata[`WATCHDOG_PERIOD_FIELD_LSB +: 4];
                watchdog_recovery_field <= pwdata[`WATCHDOG_RECOVERY_FIELD_LSB +: 4];
            end
        end
    end

    // all-zero period and recovery means no watchdog at all
    // registered, so the gating takes up a new period one cycle after the write
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_infinite <= 1'b0;
        end else begin
            wd_infinite <= (watchdog_period_field == 4'h0) && (watchdog_recovery_field == 4'h0);
        end
    end

    // ----------------------------------------
    // safety gating
    // ----------------------------------------
    // kept in its own module so every safety output leaves a flip-flop
    safety_override u_override (
        .pclk(pclk),
        .presetn(presetn),
        .debug_on(debug_active_flag),
        .wd_infinite(wd_infinite),
        .wd_error_in(wd_error_in),
        .reset_timer_expired_in(reset_timer_expired_in),
        .fault_count_max_in(fault_count_max_in),
        .fault_request_in(fault_request_in),
        .wd_error(wd_error),
        .reset_timer_expired(reset_timer_expired),
        .failsafe_entry(failsafe_entry),
        .safety_fault_output_n(safety_fault_output_n)
    );

    // ----------------------------------------
    // apb read data and answer
    // ----------------------------------------
    // unused bits and unmapped offsets read as zero
    always @* begin
        next_rdata = 32'h0000_0000;
        case (paddr)
            `OFS_SYS_CFG: next_rdata[`BIT_TRX_ACTIVE] = transceivers_active;
            `OFS_SYS1_CFG: begin
                next_rdata[`BIT_DEBUG_ACTIVE] = debug_active_flag;
                next_rdata[`BIT_PROG_ACTIVE] = prog_mode;
                next_rdata[`BIT_LOCK_INIT] = lock_init;
            end
            `OFS_WDW_CFG: begin
                next_rdata[`WATCHDOG_PERIOD_FIELD_LSB +: 4] = watchdog_period_field;
                next_rdata[`WATCHDOG_RECOVERY_FIELD_LSB +: 4] = watchdog_recovery_field;
            end
            `OFS_STATUS: begin
                next_rdata[`BIT_INIT_STATE] = init_state;
                next_rdata[`BIT_NORMAL_STATE] = normal_state;
                next_rdata[`BIT_WD_INFINITE] = wd_infinite;
            end
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // read data captured in setup, pready raised for exactly the access cycle
    // pslverr only flags the offset; a refused write to a locked field is silent
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            if (rd_en) begin
                prdata <= next_rdata;
            end
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
        end
    end

endmodule

// file: verilog/level_filter.v
`include "mode_entry_consts.vh"

// counts consecutive cycles of a qualified comparator level
module level_filter #(
    parameter CYCLES = `DBG_FILT_CYCLES,
    parameter WIDTH = 12
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // control
    input wire enable,
    input wire level,
    // result
    output reg passed
);

    reg [WIDTH-1:0] count;

    // ----------------------------------------
    // filter counter
    // ----------------------------------------
    // any drop of the level restarts the count, so a glitch never qualifies
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= {WIDTH{1'b0}};
            passed <= 1'b0;
        end else if (!enable || !level) begin
            count <= {WIDTH{1'b0}};
            passed <= 1'b0;
        end else if (count == CYCLES[WIDTH-1:0] - 1'b1) begin
            passed <= 1'b1;
        end else begin
            count <= count + 1'b1;
            passed <= 1'b0;
        end
    end

endmodule

// file: verilog/mode_entry_consts.vh
`ifndef MODE_ENTRY_CONSTS_VH
`define MODE_ENTRY_CONSTS_VH

// ----------------------------------------
// clock and filter timing
// ----------------------------------------
`define CLK_PERIOD_NS 20
`define DBG_FILT_MIN_NS 4000
`define PRG_FILT_MIN_NS 4000
// least times round up to whole cycles
`define DBG_FILT_CYCLES ((`DBG_FILT_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PRG_FILT_CYCLES ((`PRG_FILT_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_SYS_CFG 12'h000
`define OFS_SYS1_CFG 12'h004
`define OFS_WDW_CFG 12'h008
`define OFS_STATUS 12'h00c

// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_ENTER_INIT 0
`define BIT_TRX_ACTIVE 1
`define BIT_DEBUG_ACTIVE 0
`define BIT_DEBUG_LEAVE 1
`define BIT_PROG_ACTIVE 2
`define BIT_LOCK_INIT 4
`define BIT_WD_REFRESH 5
`define WATCHDOG_PERIOD_FIELD_LSB 0
`define WATCHDOG_RECOVERY_FIELD_LSB 4
`define BIT_INIT_STATE 0
`define BIT_NORMAL_STATE 1
`define BIT_WD_INFINITE 2

// ----------------------------------------
// reset values
// ----------------------------------------
`define WATCHDOG_PERIOD_FIELD_RST 4'h3
`define WATCHDOG_RECOVERY_FIELD_RST 4'h3

`endif

// file: verilog/safety_override.v
`include "mode_entry_consts.vh"

// gates the safety functions while debug mode is active
module safety_override (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // mode inputs
    input wire debug_on,
    input wire wd_infinite,
    // raw safety requests
    input wire wd_error_in,
    input wire reset_timer_expired_in,
    input wire fault_count_max_in,
    input wire fault_request_in,
    // gated results
    output reg wd_error,
    output reg reset_timer_expired,
    output reg failsafe_entry,
    output reg safety_fault_output_n
);

    // ----------------------------------------
    // gating
    // ----------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_error <= 1'b0;
            reset_timer_expired <= 1'b0;
            failsafe_entry <= 1'b0;
            safety_fault_output_n <= 1'b0;
        end else begin
            wd_error <= wd_error_in && !debug_on && !wd_infinite;
            reset_timer_expired <= reset_timer_expired_in && !debug_on;
            failsafe_entry <= fault_count_max_in && !debug_on;
            // low while debug active, else follows the safety request
            safety_fault_output_n <= !(debug_on || fault_request_in);
        end
    end

endmodule
